// [rtl/ascr_pkg.sv]
// Shared constants and types for the ADC serial control register block
package ascr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Control word layout
    localparam int CTRL_WIDTH = 5;
    localparam int CHAN_WIDTH = 3;
    localparam int CHAN_MSB = 4;
    localparam int CHAN_LSB = 2;
    localparam int SOFT_CONVERT_BIT = 1;
    localparam int STANDBY_SELECT_BIT = 0;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock edge numbers within one write frame
    localparam int EDGE_CNT_WIDTH = 3;
    localparam logic [2:0] EDGE_FIRST = 3'h1;
    localparam logic [2:0] EDGE_SOFT_CONVERT = 3'h4;
    localparam logic [2:0] EDGE_LAST_BIT = 3'h5;
    localparam logic [2:0] EDGE_LOAD = 3'h6;
    localparam logic [2:0] EDGE_STANDBY = 3'h7;
    localparam logic [2:0] EDGE_CNT_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int REF_CLK_MHZ = 40;
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Settling pulse states
    typedef enum logic [1:0] {
        SETTLE_IDLE,
        SETTLE_CHARGED,
        SETTLE_DISCHARGE
    } ascr_settle_state_t;

endpackage

// [rtl/ascr_sync.sv]
// Two flip-flop level synchroniser into the reference clock domain
`timescale 1ns/100ps
`default_nettype none

module ascr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_clk,                 // Destination clock
    input wire logic i_rst,                 // Synchronous reset, active high
    input wire logic [WIDTH-1:0] i_async,   // Levels from another domain
    output logic [WIDTH-1:0] o_sync         // Synchronised levels
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
        end
    end

    assign o_sync = stage2_reg;

endmodule

`default_nettype wire

// [rtl/ascr_control_reg.sv]
// Serial-loaded conversion control register with settling pulse and start logic
`timescale 1ns/100ps
`default_nettype none

module ascr_control_reg #(
    parameter int SETTLE_CYCLES = ascr_pkg::SETTLE_CYCLES
) (
    input wire logic i_ref_clk,                 // Reference clock, 40 MHz
    input wire logic i_rst,                     // Reset, active high; synchronous in the reference domain, asynchronous in the link domain
    input wire logic i_sclk,                    // Serial clock from host
    input wire logic i_transmit_frame_sync_n,   // Write frame, active low
    input wire logic i_sdata,                   // Serial control data
    input wire logic i_hw_convert_start_n,      // Hardware start pin
    output logic [2:0] o_channel_sel,           // Multiplexer channel code
    output logic o_soft_convert,                // Soft convert bit held
    output logic o_standby,                     // Power-down state
    output logic o_settle_active,               // Settling pulse active
    output logic o_hold_start,                  // Hold and start pulse
    output logic o_write_aborted                // Short frame pulse
);

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYCLES);
    localparam logic [CW-1:0] SETTLE_ONE = CW'(1);
    localparam logic [CW-1:0] SETTLE_ZERO = '0;
    localparam logic [4:0] SYNC_RESET = 5'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: serial clock, frame sync and data

    logic link_fresh_reg;
    logic [2:0] link_cnt_reg;
    logic [4:0] link_shift_reg;
    logic link_soft_convert_bit_reg;
    logic link_reach4_reg;
    logic link_reach6_reg;
    logic link_reach7_reg;
    wire link_restart;
    wire link_in_frame;
    wire link_cnt_full;
    wire [2:0] link_cnt_next;
    wire link_shift_en;
    wire [4:0] link_shift_next;

    assign link_restart = i_rst | i_transmit_frame_sync_n;
    assign link_in_frame = ~i_transmit_frame_sync_n;
    assign link_cnt_full = (link_cnt_reg == ascr_pkg::EDGE_STANDBY);

    assign link_cnt_next = link_fresh_reg ? ascr_pkg::EDGE_FIRST :
                           link_cnt_full ? ascr_pkg::EDGE_STANDBY :
                           3'(link_cnt_reg + 3'h1);

    assign link_shift_en = link_in_frame & (link_cnt_next <= ascr_pkg::EDGE_LAST_BIT);
    assign link_shift_next = {link_shift_reg[3:0], i_sdata};

    // Marks the next falling edge as the first of a new frame
    always_ff @(negedge i_sclk or posedge link_restart) begin
        if (link_restart) begin
            link_fresh_reg <= 1'b1;
        end else begin
            link_fresh_reg <= 1'b0;
        end
    end

    // Count and word stay put after the frame until the next one begins
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            link_cnt_reg <= ascr_pkg::EDGE_CNT_RESET;
        end else if (link_in_frame) begin
            link_cnt_reg <= link_cnt_next;
        end
    end

    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            link_shift_reg <= ascr_pkg::CTRL_RESET;
        end else if (link_shift_en) begin
            link_shift_reg <= link_shift_next;
        end
    end

    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            link_soft_convert_bit_reg <= 1'b0;
        end else if (link_in_frame && link_cnt_next == ascr_pkg::EDGE_SOFT_CONVERT) begin
            link_soft_convert_bit_reg <= i_sdata;
        end
    end

    // Progress flags, levels for the crossing
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            link_reach4_reg <= 1'b0;
            link_reach6_reg <= 1'b0;
            link_reach7_reg <= 1'b0;
        end else if (link_in_frame) begin
            link_reach4_reg <= (link_cnt_next >= ascr_pkg::EDGE_SOFT_CONVERT);
            link_reach6_reg <= (link_cnt_next >= ascr_pkg::EDGE_LOAD);
            link_reach7_reg <= (link_cnt_next == ascr_pkg::EDGE_STANDBY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the reference domain

    wire [4:0] sync_in;
    wire [4:0] sync_out;
    wire tfs_n_s;
    wire hw_start_n_s;
    wire reach4_s;
    wire reach6_s;
    wire reach7_s;

    assign sync_in = {i_transmit_frame_sync_n, i_hw_convert_start_n,
                      link_reach4_reg, link_reach6_reg, link_reach7_reg};

    ascr_sync #(
        .WIDTH(5),
        .RESET_VALUE(SYNC_RESET)
    ) u_sync (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign tfs_n_s = sync_out[4];
    assign hw_start_n_s = sync_out[3];
    assign reach4_s = sync_out[2];
    assign reach6_s = sync_out[1];
    assign reach7_s = sync_out[0];

    logic tfs_n_prev_reg;
    logic hw_start_n_prev_reg;
    logic reach6_prev_reg;
    logic reach7_prev_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tfs_n_prev_reg <= 1'b1;
            hw_start_n_prev_reg <= 1'b1;
            reach6_prev_reg <= 1'b0;
            reach7_prev_reg <= 1'b0;
        end else begin
            tfs_n_prev_reg <= tfs_n_s;
            hw_start_n_prev_reg <= hw_start_n_s;
            reach6_prev_reg <= reach6_s;
            reach7_prev_reg <= reach7_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events in the reference domain

    wire frame_start_ev;
    wire frame_end_ev;
    wire load_ev;
    wire standby_ev;
    wire early_soft_convert_ev;
    wire abort_ev;
    wire hw_rise_ev;

    assign frame_start_ev = tfs_n_prev_reg & ~tfs_n_s;
    assign frame_end_ev = ~tfs_n_prev_reg & tfs_n_s;
    assign load_ev = ~reach6_prev_reg & reach6_s;
    assign standby_ev = ~reach7_prev_reg & reach7_s;
    assign early_soft_convert_ev = frame_end_ev & reach4_s & ~reach6_s & link_soft_convert_bit_reg;
    assign abort_ev = frame_end_ev & ~reach6_s & ~early_soft_convert_ev;
    assign hw_rise_ev = ~hw_start_n_prev_reg & hw_start_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    logic [4:0] ctrl_reg;
    logic standby_reg;
    wire [4:0] ctrl_next;
    wire new_standby_bit;
    wire new_soft_bit;
    wire standby_next;

    assign ctrl_next = load_ev ? link_shift_reg : ctrl_reg;
    assign new_standby_bit = link_shift_reg[ascr_pkg::STANDBY_SELECT_BIT];
    assign new_soft_bit = link_shift_reg[ascr_pkg::SOFT_CONVERT_BIT];

    assign standby_next = (standby_ev & new_standby_bit) ? 1'b1 :
                          (load_ev & ~new_standby_bit) ? 1'b0 :
                          standby_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_reg <= ascr_pkg::CTRL_RESET;
            standby_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            standby_reg <= standby_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settling pulse

    ascr_pkg::ascr_settle_state_t settle_state_reg;
    ascr_pkg::ascr_settle_state_t settle_state_next;
    logic [CW-1:0] settle_cnt_reg;
    logic [CW-1:0] settle_cnt_next;
    wire discharge_start;
    wire settle_done;

    assign discharge_start = load_ev | (frame_end_ev & ~reach6_s);
    assign settle_done = (settle_cnt_reg <= SETTLE_ONE);

    always_comb begin
        settle_state_next = settle_state_reg;
        settle_cnt_next = settle_cnt_reg;
        unique case (settle_state_reg)
            ascr_pkg::SETTLE_IDLE: begin
                if (frame_start_ev) begin
                    settle_state_next = ascr_pkg::SETTLE_CHARGED;
                end
            end
            ascr_pkg::SETTLE_CHARGED: begin
                if (discharge_start) begin
                    settle_state_next = ascr_pkg::SETTLE_DISCHARGE;
                    settle_cnt_next = SETTLE_LOAD;
                end
            end
            ascr_pkg::SETTLE_DISCHARGE: begin
                if (frame_start_ev) begin
                    settle_state_next = ascr_pkg::SETTLE_CHARGED;
                end else if (settle_done) begin
                    settle_state_next = ascr_pkg::SETTLE_IDLE;
                    settle_cnt_next = SETTLE_ZERO;
                end else begin
                    settle_cnt_next = CW'(settle_cnt_reg - SETTLE_ONE);
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            settle_state_reg <= ascr_pkg::SETTLE_IDLE;
            settle_cnt_reg <= SETTLE_ZERO;
        end else begin
            settle_state_reg <= settle_state_next;
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion start

    logic soft_pending_reg;
    wire settle_idle;
    wire soft_request;
    wire soft_fire;
    wire hw_fire;
    wire hold_start_next;
    wire soft_pending_next;
    wire settle_active_next;

    assign settle_idle = (settle_state_next == ascr_pkg::SETTLE_IDLE) &
                         (settle_state_reg == ascr_pkg::SETTLE_IDLE);
    assign settle_active_next = (settle_state_next != ascr_pkg::SETTLE_IDLE);

    assign soft_request = (load_ev & new_soft_bit) | early_soft_convert_ev;

    assign soft_fire = soft_pending_reg & settle_idle;

    assign hw_fire = hw_rise_ev & ~ctrl_reg[ascr_pkg::SOFT_CONVERT_BIT] & settle_idle;

    assign hold_start_next = soft_fire | hw_fire;

    assign soft_pending_next = soft_request ? 1'b1 :
                               soft_fire ? 1'b0 :
                               soft_pending_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            soft_pending_reg <= 1'b0;
        end else begin
            soft_pending_reg <= soft_pending_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic [2:0] channel_sel_reg;
    logic soft_convert_reg;
    logic standby_out_reg;
    logic settle_active_reg;
    logic hold_start_reg;
    logic write_aborted_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            channel_sel_reg <= 3'h0;
            soft_convert_reg <= 1'b0;
            standby_out_reg <= 1'b0;
            settle_active_reg <= 1'b0;
            hold_start_reg <= 1'b0;
            write_aborted_reg <= 1'b0;
        end else begin
            channel_sel_reg <= ctrl_next[ascr_pkg::CHAN_MSB:ascr_pkg::CHAN_LSB];
            soft_convert_reg <= ctrl_next[ascr_pkg::SOFT_CONVERT_BIT];
            standby_out_reg <= standby_next;
            settle_active_reg <= settle_active_next;
            hold_start_reg <= hold_start_next;
            write_aborted_reg <= abort_ev;
        end
    end

    assign o_channel_sel = channel_sel_reg;
    assign o_soft_convert = soft_convert_reg;
    assign o_standby = standby_out_reg;
    assign o_settle_active = settle_active_reg;
    assign o_hold_start = hold_start_reg;
    assign o_write_aborted = write_aborted_reg;

endmodule

`default_nettype wire

// [sim/ascr_control_reg_sva.sv]
// Port checker for the serial control register
`timescale 1ns/100ps
`default_nettype none
module ascr_control_reg_sva #(
    parameter int SETTLE_CYCLES = ascr_pkg::SETTLE_CYCLES
) (
    input wire logic i_ref_clk,               // Reference clock
    input wire logic i_rst,                   // Reset
    input wire logic i_sclk,                  // Serial clock
    input wire logic i_transmit_frame_sync_n, // Frame
    input wire logic i_sdata,                 // Serial data
    input wire logic i_hw_convert_start_n,    // Hardware start pin
    input wire logic [2:0] o_channel_sel,     // Channel code
    input wire logic o_soft_convert,          // Soft convert bit
    input wire logic o_standby,               // Power-down
    input wire logic o_settle_active,         // Settling pulse
    input wire logic o_hold_start,            // Start pulse
    input wire logic o_write_aborted          // Short frame pulse
);
    logic [2:0] link_edges;
    logic [3:0] idle_cnt;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Falling serial edges in the current frame, saturating at seven
    always_ff @(negedge i_sclk or posedge i_transmit_frame_sync_n) begin
        if (i_transmit_frame_sync_n) begin
            link_edges <= 3'h0;
        end else if (link_edges != 3'h7) begin
            link_edges <= link_edges + 3'h1;
        end
    end
    // Cycles with no frame and no settling pulse
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || o_settle_active || !i_transmit_frame_sync_n) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hf) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_reset_clear;
        $fell(i_rst) |-> (o_channel_sel == 3'h0) && !o_soft_convert && !o_standby;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
    property p_no_start_settle;
        o_settle_active |-> !o_hold_start;
    endproperty
    a_no_start_settle: assert property (p_no_start_settle) else $error("start while settling");
    property p_hold_after_settle;
        $fell(o_settle_active) && o_soft_convert |-> ##[0:2] o_hold_start;
    endproperty
    a_hold_after_settle: assert property (p_hold_after_settle) else $error("no start after settle");
    property p_soft_once;
        o_hold_start && o_soft_convert |=> (!o_hold_start) [*8];
    endproperty
    a_soft_once: assert property (p_soft_once) else $error("repeated soft start");
    property p_hw_start;
        $rose(i_hw_convert_start_n) && !o_soft_convert && (idle_cnt >= 4'h4) |-> ##[1:4] o_hold_start;
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("hardware start missed");
    property p_hw_ignored;
        $rose(i_hw_convert_start_n) && o_soft_convert && (idle_cnt >= 4'h4) |=> (!o_hold_start) [*5];
    endproperty
    a_hw_ignored: assert property (p_hw_ignored) else $error("hardware start not ignored");
    property p_standby_late;
        $rose(o_standby) |-> (link_edges == 3'h7);
    endproperty
    a_standby_late: assert property (p_standby_late) else $error("standby before seventh edge");
    property p_abort_keeps;
        o_write_aborted |-> $stable(o_channel_sel) && $stable(o_soft_convert) && $stable(o_standby);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("short frame changed register");
endmodule
bind ascr_control_reg ascr_control_reg_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(i_sclk),
    .i_transmit_frame_sync_n(i_transmit_frame_sync_n), .i_sdata(i_sdata),
    .i_hw_convert_start_n(i_hw_convert_start_n), .o_channel_sel(o_channel_sel),
    .o_soft_convert(o_soft_convert), .o_standby(o_standby), .o_settle_active(o_settle_active),
    .o_hold_start(o_hold_start), .o_write_aborted(o_write_aborted));
`default_nettype wire

// [sim/ascr_host_model.sv]
// Serial port host that writes the control word
`timescale 1ns/100ps
`default_nettype none
module ascr_host_model (
    output logic o_sclk,   // Serial clock, still between frames
    output logic o_frame_n, // Write frame, active low
    output logic o_sdata   // Serial data
);
    initial begin
        o_sclk = 1'b1;
        o_frame_n = 1'b1;
        o_sdata = 1'b0;
    end
    // n clocks, word MSB first, filler after bit five
    task automatic send(input logic [4:0] w, input int n);
        int k;
        #3.3;
        o_frame_n = 1'b0;
        for (k = 1; k <= n; k++) begin
            o_sdata = (k <= 5) ? w[5-k] : ~o_sdata;
            #24 o_sclk = 1'b0;
            #24 o_sclk = 1'b1;
        end
        #200 o_frame_n = 1'b1;
        o_sdata = ~o_sdata;
        #100;
    endtask
endmodule
`default_nettype wire

// [sim/adc_serial_control_register_bench.sv]
// Self-checking bench for the serial control register
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module adc_serial_control_register_bench;
    logic i_ref_clk = 1'b0;
    // Starts unknown so the rise at time zero clears the link flops
    logic i_rst;
    logic i_hw_convert_start_n = 1'b1;
    wire sclk, frame_n, sdata;
    logic [2:0] o_channel_sel;
    logic o_soft_convert, o_standby, o_settle_active, o_hold_start, o_write_aborted;
    logic [4:0] exp_q[$];
    logic [4:0] exp_v;
    logic [4:0] mon_v;
    logic abort_seen;
    int fail_count = 0;
    int n_tests = 0;
    int i;
    always #12.5 i_ref_clk = ~i_ref_clk;
    ascr_host_model host (.o_sclk(sclk), .o_frame_n(frame_n), .o_sdata(sdata));
    ascr_control_reg #(.SETTLE_CYCLES(4)) DUT (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(sclk), .i_transmit_frame_sync_n(frame_n),
        .i_sdata(sdata), .i_hw_convert_start_n(i_hw_convert_start_n),
        .o_channel_sel(o_channel_sel), .o_soft_convert(o_soft_convert), .o_standby(o_standby),
        .o_settle_active(o_settle_active), .o_hold_start(o_hold_start),
        .o_write_aborted(o_write_aborted));
    ////////////////////////////////////////////////////////////////////////////
    // Each start pulse consumes the oldest expected register state
    always @(negedge i_ref_clk) begin
        if (o_hold_start === 1'b1) begin
            // An unexpected start is forced to mismatch
            if (exp_q.size() == 0) begin
                mon_v = ~{o_channel_sel, o_soft_convert, o_standby};
            end else begin
                mon_v = exp_q.pop_front();
            end
            `CHECK({o_channel_sel, o_soft_convert, o_standby}, mon_v)
        end
    end
    task automatic summarize;
        `CHECK(exp_q.size(), 0)
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_idle;
        int k;
        repeat (8) @(posedge i_ref_clk);
        for (k = 0; k < 200 && o_settle_active !== 1'b0; k++) @(posedge i_ref_clk);
        if (k == 200) begin
            fail_count++;
            summarize();
        end
        repeat (6) @(posedge i_ref_clk);
    endtask
    task automatic hw_pulse;
        @(posedge i_ref_clk);
        i_hw_convert_start_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        i_hw_convert_start_n <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
    endtask
    task automatic short_frame(input logic [4:0] w);
        int k;
        abort_seen = 1'b0;
        fork
            host.send(w, 4);
            for (k = 0; k < 40; k++) begin
                @(negedge i_ref_clk);
                if (o_write_aborted === 1'b1) abort_seen = 1'b1;
            end
        join
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst <= 1'b1;
        void'($urandom(56));
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        // channel sweep with random standby, hardware starts
        for (i = 0; i < 8; i++) begin
            exp_v = {i[2:0], 1'b0, 1'($urandom % 2)};
            host.send(exp_v, 7);
            wait_idle();
            `CHECK(o_standby, exp_v[0])
            exp_q.push_back(exp_v);
            hw_pulse();
        end
        $display("Test channel sweep done");
        // soft start, then a refused hardware start
        exp_v = {3'($urandom % 8), 2'b10};
        exp_q.push_back(exp_v);
        host.send(exp_v, 6);
        wait_idle();
        `CHECK(o_soft_convert, 1'b1)
        hw_pulse();
        $display("Test soft convert done");
        // short frame leaves the register alone
        host.send(5'h14, 6);
        wait_idle();
        short_frame(5'h08);
        `CHECK(abort_seen, 1'b1)
        wait_idle();
        exp_q.push_back(5'h14);
        hw_pulse();
        // short frame with soft bit still starts, no abort
        exp_q.push_back(5'h14);
        short_frame(5'h1a);
        `CHECK(abort_seen, 1'b0)
        wait_idle();
        $display("Test short frames done");
        host.send(5'h05, 6);
        wait_idle();
        `CHECK(o_standby, 1'b0)
        exp_q.push_back(5'h04);
        hw_pulse();
        $display("Test standby edge done");
        summarize();
    end
endmodule
`default_nettype wire
